// [core/prc_defs.vh]
// Constants for the transceiver reset controller: register offsets, bits, reset values, times.
// Assumes a 100 MHz clock and 16-bit registers at 32-bit APB word offsets.
`ifndef PRC_DEFS_VH
`define PRC_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PRC_OFF_BASIC_MODE_CONTROL 12'h000
`define PRC_OFF_PHY_CONTROL_TWO 12'h004
`define PRC_OFF_TIME_SYNC_CONTROL 12'h008
`define PRC_OFF_CLOCK_OUTPUT_CONFIG 12'h00c
`define PRC_OFF_TIME_CLOCK_SOURCE 12'h010
`define PRC_OFF_TIME_SYNC_DATA 12'h014
`define PRC_OFF_STATUS 12'h018
`define PRC_OFF_STRAP 12'h01c

// ****************************************
// Field positions
// ****************************************
`define PRC_BMC_RESET_BIT 15
`define PRC_PC2_SOFT_RESET_BIT 9
`define PRC_TSC_RESET_BIT 0

// ****************************************
// Reset values
// ****************************************
`define PRC_BMC_RESET_VAL 16'h3100
`define PRC_PC2_RESET_VAL 16'h0000
`define PRC_TSC_RESET_VAL 16'h0000
`define PRC_COC_RESET_VAL 16'h0000
`define PRC_CLKSRC_RESET_VAL 16'h0000
`define PRC_TSD_RESET_VAL 16'h0000

// ****************************************
// Timing
// ****************************************
`define PRC_CLK_MHZ 100
`define PRC_HW_RESET_NS 1000
`define PRC_SW_RESET_NS 1000
`define PRC_SW_WAIT_NS 3000
`define PRC_POR_CYCLES 16
`define PRC_HW_RESET_CYC ((`PRC_HW_RESET_NS * `PRC_CLK_MHZ + 999) / 1000)
`define PRC_SW_RESET_CYC ((`PRC_SW_RESET_NS * `PRC_CLK_MHZ) / 1000)
`define PRC_DP_RESET_CYC 8
`define PRC_TS_RESET_CYC 8

`endif

// [core/prc_reset_control.v]
// Reset controller for a single-port transceiver with a time-sync clock, APB registers.
// Assumes one 100 MHz clock, an asynchronous active-low reset pin and strap pins.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "prc_defs.vh"

module prc_reset_control #(
    parameter STRAP_W = 8,
    parameter POR_CYC = `PRC_POR_CYCLES,
    parameter HW_CYC = `PRC_HW_RESET_CYC,
    parameter SW_CYC = `PRC_SW_RESET_CYC,
    parameter DP_CYC = `PRC_DP_RESET_CYC,
    parameter TS_CYC = `PRC_TS_RESET_CYC
) (
    input wire clk,
    input wire reset,
    input wire reset_pin_n,
    input wire [STRAP_W-1:0] strap_in,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    output reg chip_reset,
    output reg datapath_reset,
    output reg time_sync_logic_reset,
    output reg mgmt_busy,
    output reg [STRAP_W-1:0] strap_latched
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [2:0] pin_sync;
    reg pin_low;
    always @(posedge clk) begin
        if (reset) begin
            pin_sync <= 3'h7;
            pin_low <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], reset_pin_n};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_low <= ~pin_sync[2];
            end
        end
    end

    // Straps pass the same three stages; only settled values are latched
    reg [STRAP_W-1:0] strap_s1;
    reg [STRAP_W-1:0] strap_s2;
    reg [STRAP_W-1:0] strap_s3;
    always @(posedge clk) begin
        if (reset) begin
            strap_s1 <= {STRAP_W{1'b0}};
            strap_s2 <= {STRAP_W{1'b0}};
            strap_s3 <= {STRAP_W{1'b0}};
        end else begin
            strap_s1 <= strap_in;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    // ****************************************
    // Strap settle filter
    // ****************************************
    // A strap bit moves only once its last two stages agree, as the pin does
    reg [STRAP_W-1:0] strap_settled;
    integer si;
    always @(posedge clk) begin
        if (reset) begin
            strap_settled <= {STRAP_W{1'b0}};
        end else begin
            for (si = 0; si < STRAP_W; si = si + 1) begin
                if (strap_s2[si] == strap_s3[si]) begin
                    strap_settled[si] <= strap_s3[si];
                end
            end
        end
    end

    // ****************************************
    // Power-on and hardware reset
    // ****************************************
    // Filter far longer than the 3-stage sync so short glitches never reset the chip
    reg [15:0] por_cnt;
    reg [15:0] low_cnt;
    reg hw_active;
    wire hw_hit = pin_low && (low_cnt >= HW_CYC[15:0] - 16'h0001);
    always @(posedge clk) begin
        if (reset) begin
            por_cnt <= 16'h0000;
            low_cnt <= 16'h0000;
            hw_active <= 1'b1;
        end else begin
            if (pin_low) begin
                if (low_cnt != 16'hffff) begin
                    low_cnt <= low_cnt + 16'h0001;
                end
            end else begin
                low_cnt <= 16'h0000;
            end
            if (hw_hit) begin
                hw_active <= 1'b1;
                por_cnt <= 16'h0000;
            end else if (hw_active) begin
                if (!pin_low && por_cnt >= POR_CYC[15:0]) begin
                    hw_active <= 1'b0;
                end else begin
                    por_cnt <= por_cnt + 16'h0001;
                end
            end
        end
    end

    // Straps are loaded on every cycle of a power-on or pin reset and held once it ends
    always @(posedge clk) begin
        if (reset) begin
            strap_latched <= {STRAP_W{1'b0}};
        end else if (hw_active) begin
            strap_latched <= strap_settled;
        end
    end

    // ****************************************
    // Software, datapath and time-sync reset timers
    // ****************************************
    reg sw_active;
    reg [15:0] sw_cnt;
    reg [15:0] busy_cnt;
    reg dp_active;
    reg [7:0] dp_cnt;
    reg ts_active;
    reg [7:0] ts_cnt;
    // Management wait runs three software reset lengths from the write
    localparam BUSY_CYC = 3 * SW_CYC;
    wire wr_en;
    wire sw_start = wr_en && paddr == `PRC_OFF_BASIC_MODE_CONTROL && pstrb[1] &&
        pwdata[`PRC_BMC_RESET_BIT];
    wire dp_start = wr_en && paddr == `PRC_OFF_PHY_CONTROL_TWO && pstrb[1] &&
        pwdata[`PRC_PC2_SOFT_RESET_BIT];
    wire ts_start = wr_en && paddr == `PRC_OFF_TIME_SYNC_CONTROL && pstrb[0] &&
        pwdata[`PRC_TSC_RESET_BIT];
    wire sw_done = sw_active && sw_cnt >= SW_CYC[15:0] - 16'h0001;
    wire dp_done = dp_active && dp_cnt >= DP_CYC[7:0] - 8'h01;
    wire ts_done = ts_active && ts_cnt >= TS_CYC[7:0] - 8'h01;
    // Register defaults return on pin/power-on reset and on full software reset
    wire reg_clear = hw_active || sw_done;

    always @(posedge clk) begin
        if (reset || hw_active) begin
            sw_active <= 1'b0;
            sw_cnt <= 16'h0000;
            busy_cnt <= 16'h0000;
        end else begin
            if (sw_start && !sw_active) begin
                sw_active <= 1'b1;
                sw_cnt <= 16'h0000;
                busy_cnt <= BUSY_CYC[15:0];
            end else if (sw_done) begin
                sw_active <= 1'b0;
            end else if (sw_active) begin
                sw_cnt <= sw_cnt + 16'h0001;
            end
            if (busy_cnt != 16'h0000 && !(sw_start && !sw_active)) begin
                busy_cnt <= busy_cnt - 16'h0001;
            end
        end
    end

    always @(posedge clk) begin
        if (reset || reg_clear) begin
            dp_active <= 1'b0;
            dp_cnt <= 8'h00;
            ts_active <= 1'b0;
            ts_cnt <= 8'h00;
        end else begin
            if (dp_start) begin
                dp_active <= 1'b1;
                dp_cnt <= 8'h00;
            end else if (dp_done) begin
                dp_active <= 1'b0;
            end else if (dp_active) begin
                dp_cnt <= dp_cnt + 8'h01;
            end
            if (ts_start) begin
                ts_active <= 1'b1;
                ts_cnt <= 8'h00;
            end else if (ts_done) begin
                ts_active <= 1'b0;
            end else if (ts_active) begin
                ts_cnt <= ts_cnt + 8'h01;
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            chip_reset <= 1'b1;
            datapath_reset <= 1'b1;
            time_sync_logic_reset <= 1'b1;
            mgmt_busy <= 1'b1;
        end else begin
            chip_reset <= hw_active || sw_active;
            datapath_reset <= hw_active || sw_active || dp_active;
            time_sync_logic_reset <= hw_active || sw_active || ts_active;
            mgmt_busy <= hw_active || busy_cnt != 16'h0000;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    reg [15:0] basic_mode_control;
    reg [15:0] phy_control_two;
    reg [15:0] time_sync_control;
    reg [15:0] clock_output_config;
    reg [15:0] time_clock_source;
    reg [15:0] time_sync_data;

    // Zero wait states; access stays open during a datapath reset
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    wire hit = paddr == `PRC_OFF_BASIC_MODE_CONTROL || paddr == `PRC_OFF_PHY_CONTROL_TWO ||
        paddr == `PRC_OFF_TIME_SYNC_CONTROL || paddr == `PRC_OFF_CLOCK_OUTPUT_CONFIG ||
        paddr == `PRC_OFF_TIME_CLOCK_SOURCE || paddr == `PRC_OFF_TIME_SYNC_DATA ||
        paddr == `PRC_OFF_STATUS || paddr == `PRC_OFF_STRAP;

    function [15:0] merge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] st;
        begin
            merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // A write that lands while a chip reset runs is lost when that reset ends

    always @(posedge clk) begin
        if (reset || reg_clear) begin
            basic_mode_control <= `PRC_BMC_RESET_VAL;
            phy_control_two <= `PRC_PC2_RESET_VAL;
            time_sync_control <= `PRC_TSC_RESET_VAL;
            clock_output_config <= `PRC_COC_RESET_VAL;
            time_clock_source <= `PRC_CLKSRC_RESET_VAL;
            time_sync_data <= `PRC_TSD_RESET_VAL;
        end else begin
            if (wr_en && paddr == `PRC_OFF_BASIC_MODE_CONTROL) begin
                basic_mode_control <= merge(basic_mode_control, pwdata, pstrb);
            end
            if (wr_en && paddr == `PRC_OFF_PHY_CONTROL_TWO) begin
                phy_control_two <= merge(phy_control_two, pwdata, pstrb);
            end else if (dp_done) begin
                phy_control_two[`PRC_PC2_SOFT_RESET_BIT] <= 1'b0;
            end
            if (wr_en && paddr == `PRC_OFF_TIME_SYNC_CONTROL) begin
                time_sync_control <= merge(time_sync_control, pwdata, pstrb);
            end else if (ts_done) begin
                time_sync_control <= `PRC_TSC_RESET_VAL;
            end
            if (wr_en && paddr == `PRC_OFF_CLOCK_OUTPUT_CONFIG) begin
                clock_output_config <= merge(clock_output_config, pwdata, pstrb);
            end
            if (wr_en && paddr == `PRC_OFF_TIME_CLOCK_SOURCE) begin
                time_clock_source <= merge(time_clock_source, pwdata, pstrb);
            end
            if (wr_en && paddr == `PRC_OFF_TIME_SYNC_DATA) begin
                time_sync_data <= merge(time_sync_data, pwdata, pstrb);
            end else if (ts_done) begin
                time_sync_data <= `PRC_TSD_RESET_VAL;
            end
        end
    end

    // Read data registered on the access edge would be a cycle late, so it is built
    // in the setup cycle where address is already stable
    reg [15:0] rd_mux;
    always @* begin
        rd_mux = 16'h0000;
        case (paddr)
            `PRC_OFF_BASIC_MODE_CONTROL: rd_mux = basic_mode_control;
            `PRC_OFF_PHY_CONTROL_TWO: rd_mux = phy_control_two;
            `PRC_OFF_TIME_SYNC_CONTROL: rd_mux = time_sync_control;
            `PRC_OFF_CLOCK_OUTPUT_CONFIG: rd_mux = clock_output_config;
            `PRC_OFF_TIME_CLOCK_SOURCE: rd_mux = time_clock_source;
            `PRC_OFF_TIME_SYNC_DATA: rd_mux = time_sync_data;
            `PRC_OFF_STATUS: rd_mux = {12'h000, mgmt_busy, ts_active, dp_active, sw_active};
            `PRC_OFF_STRAP: rd_mux = {{(16-STRAP_W){1'b0}}, strap_latched};
            default: rd_mux = 16'h0000;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            if (psel && !penable && !pwrite) begin
                prdata <= {16'h0000, rd_mux};
            end else if (rd_en) begin
                prdata <= 32'h0000_0000;
            end
            pslverr <= psel && !penable && !hit;
        end
    end

endmodule // prc_reset_control

// [sim/prc_reset_control_checker.sv]
// Assertions on the reset controller ports.
// Assumes SW_CYC 4 and HW_CYC 4 from the bench, DP_CYC and TS_CYC at 8.
`timescale 1ns/10ps
module prc_reset_control_checker #(
    parameter STRAP_W = 8
) (
    input wire clk,
    input wire reset,
    input wire reset_pin_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire chip_reset,
    input wire datapath_reset,
    input wire time_sync_logic_reset,
    input wire mgmt_busy,
    input wire [STRAP_W-1:0] strap_latched
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Writes during chip reset are lost, so they start nothing
    wire wr = psel && penable && pwrite && !chip_reset;
    wire sw_req = wr && paddr == 12'h000 && pwdata[15] && pstrb[1];
    wire dp_req = wr && paddr == 12'h004 && pwdata[9] && pstrb[1];
    wire ts_req = wr && paddr == 12'h008 && pwdata[0] && pstrb[0];
    por_hold_a:
        assert property ($fell(reset) |-> chip_reset [*3]) else $error("No power-on hold");
    pin_reset_a:
        assert property (!reset_pin_n [*8] |-> ##[0:4] chip_reset) else $error("Pin ignored");
    sw_start_a:
        assert property (sw_req |-> ##2 chip_reset && mgmt_busy) else $error("No soft reset");
    sw_len_a:
        assert property (sw_req |-> ##2 chip_reset [*4] ##1 !chip_reset) else $error("Length");
    strap_keep_a:
        assert property (sw_req |=> ($stable(strap_latched)) [*6]) else $error("Straps moved");
    busy_wait_a:
        assert property (sw_req |-> ##2 mgmt_busy [*8] ##1 mgmt_busy [*4] ##1 !mgmt_busy)
            else $error("Busy");
    dp_only_a:
        assert property (dp_req |-> ##2 datapath_reset && !chip_reset) else $error("Datapath");
    dp_len_a:
        assert property (dp_req |-> ##2 datapath_reset [*8] ##1 !datapath_reset)
            else $error("Datapath length");
    ts_only_a:
        assert property (ts_req |-> ##2 time_sync_logic_reset && !chip_reset && !datapath_reset)
            else $error("Time sync reset");
    cover property (sw_req);
    cover property (dp_req);
    cover property (ts_req);
endmodule // prc_reset_control_checker
bind prc_reset_control prc_reset_control_checker #(.STRAP_W(STRAP_W)) prc_reset_control_checker_i (
    .clk(clk), .reset(reset), .reset_pin_n(reset_pin_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .chip_reset(chip_reset),
    .datapath_reset(datapath_reset), .time_sync_logic_reset(time_sync_logic_reset),
    .mgmt_busy(mgmt_busy), .strap_latched(strap_latched));

// [sim/prc_mgmt_model.sv]
// Management controller side: drives the reset pin.
// Assumes pin_pulse is called right after a clock edge.
`timescale 1ns/10ps
module prc_mgmt_model (
    input wire clk,
    output logic reset_pin_n
);
    // ****************************************
    // Reset pin
    // ****************************************
    initial reset_pin_n = 1'b1;
    // Held low whole cycles so the width seen by the sync flops is exact
    task automatic pin_pulse(input int n);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask
endmodule // prc_mgmt_model

// [sim/phy_reset_control_tb_top.sv]
// Self-checking bench for the reset controller.
// Assumes short reset counts; expectations come from bench functions.
`timescale 1ns/10ps
module phy_reset_control_tb_top;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, se;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, coc, src, tsd;
    logic [7:0] strap_in = 0, strap_lt;
    logic [3:0] pstrb = 4'hf;
    wire [7:0] strap_q;
    wire [31:0] prdata;
    wire reset_pin_n, pready, pslverr, chip_reset, dp_rst, ts_rst, mgmt_busy;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    prc_reset_control #(.POR_CYC(4), .HW_CYC(4), .SW_CYC(4))
        prc_reset_control_i (.clk(clk), .reset(reset), .reset_pin_n(reset_pin_n),
        .strap_in(strap_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_reset(chip_reset), .datapath_reset(dp_rst), .time_sync_logic_reset(ts_rst),
        .mgmt_busy(mgmt_busy), .strap_latched(strap_q));
    prc_mgmt_model prc_mgmt_model_i (.clk(clk), .reset_pin_n(reset_pin_n));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    function automatic logic [31:0] lo16(input logic [31:0] v);
        return {16'h0000, v[15:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 40) begin
            n++;
            @(posedge clk);
        end
        if (n == 40) error_cnt++;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // Bounded wait for chip reset and the busy window to end
    task automatic idle();
        int n;
        n = 0;
        // Status outputs are registered: a request just taken shows two edges later
        repeat (2) @(posedge clk);
        while ((chip_reset !== 1'b0 || mgmt_busy !== 1'b0) && n < 1000) begin
            n++;
            @(posedge clk);
        end
        if (n == 1000) error_cnt++;
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hc5a0_c0bb));
        strap_lt = $urandom();
        strap_in <= strap_lt;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        idle();
        rchk(12'h000, 32'h0000_3100);
        rchk(12'h01c, {24'h00_0000, strap_lt});
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(32'(se), 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_8000, 4'h1);
        rchk(12'h000, 32'h0000_3100);
        chk(32'(chip_reset), 32'h0000_0000);
        $display("Test power-up done");
        coc = $urandom();
        src = $urandom();
        tsd = $urandom();
        apb(1'b1, 12'h00c, coc);
        apb(1'b1, 12'h010, src);
        apb(1'b1, 12'h014, tsd);
        apb(1'b1, 12'h004, 32'h0000_0200);
        rchk(12'h018, 32'h0000_0002);
        rchk(12'h00c, lo16(coc));
        repeat (12) @(posedge clk);
        rchk(12'h004, 32'h0000_0000);
        rchk(12'h014, lo16(tsd));
        $display("Test datapath reset done");
        apb(1'b1, 12'h008, 32'h0000_0001);
        repeat (12) @(posedge clk);
        rchk(12'h008, 32'h0000_0000);
        rchk(12'h014, 32'h0000_0000);
        rchk(12'h00c, lo16(coc));
        rchk(12'h010, lo16(src));
        $display("Test time-sync reset done");
        strap_in <= ~strap_lt;
        apb(1'b1, 12'h000, 32'h0000_b100);
        idle();
        rchk(12'h000, 32'h0000_3100);
        rchk(12'h00c, 32'h0000_0000);
        rchk(12'h01c, {24'h00_0000, strap_lt});
        apb(1'b1, 12'h00c, coc, 4'h2);
        rchk(12'h00c, {16'h0000, coc[15:8], 8'h00});
        $display("Test software reset done");
        apb(1'b1, 12'h00c, coc);
        prc_mgmt_model_i.pin_pulse(1);
        repeat (8) @(posedge clk);
        rchk(12'h00c, lo16(coc));
        prc_mgmt_model_i.pin_pulse(20);
        idle();
        rchk(12'h01c, {24'h00_0000, ~strap_lt});
        rchk(12'h00c, 32'h0000_0000);
        chk({24'h00_0000, strap_q}, {24'h00_0000, ~strap_lt});
        $display("Test hardware reset done");
        end_of_test();
    end
endmodule // phy_reset_control_tb_top
